// [rtl/tos_pkg.sv]
// Package for the string torque-off release and status block.
// Assumes one 10 MHz system clock shared by all users of these constants.
package tos_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int NUM_STRINGS = 2;
  localparam int DRIVES_PER_STRING = 8;
  // Tolerated low test pulse, in microseconds
  localparam int PULSE_TOL_US = 300;
  localparam int PULSE_TOL_CYC = (PULSE_TOL_US * (CLK_HZ / 1_000_000));
  // Least spacing between tolerated pulses, in milliseconds
  localparam int PULSE_GAP_MS = 200;
  localparam int PULSE_GAP_CYC = PULSE_GAP_MS * (CLK_HZ / 1000);
  // Longest reaction to a removed release, in milliseconds
  localparam int REACT_MAX_MS = 10;
  localparam int REACT_MAX_CYC = REACT_MAX_MS * (CLK_HZ / 1000);
  localparam logic RELEASE_RST = 1'b0;
  localparam logic STATUS_RST = 1'b1;

  typedef struct packed {
    logic [DRIVES_PER_STRING-1:0] present;
    logic [DRIVES_PER_STRING-1:0] commLost;
    logic [DRIVES_PER_STRING-1:0] driveTorqueOff;
    logic [DRIVES_PER_STRING-1:0] localTorqueOffOption;
    logic [DRIVES_PER_STRING-1:0] localRelease;
    logic [DRIVES_PER_STRING-1:0] autoEnableAtPowerup;
  } tos_drive_info_t;
endpackage

// [rtl/tos_release_filter.sv]
// One string's release input filter.
// Assumes the input is already synchronised to clk.
module tos_release_filter
  import tos_pkg::*;
#(
  parameter int TOL_CYC = PULSE_TOL_CYC,
  parameter int GAP_CYC = PULSE_GAP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic releaseSync,
  output logic released
);
  if (TOL_CYC < 1 || GAP_CYC < 1) begin : gBadCounts
    $error("tos_release_filter: counts must be at least one");
  end

  logic [31:0] lowCount;
  logic [31:0] highCount;
  logic gapMet;

  ////////////////////////////////////////////////////////////////////////
  // Low time counter, saturating past the tolerance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lowCount <= 32'h0;
    end else if (releaseSync) begin
      lowCount <= 32'h0;
    end else if (lowCount <= 32'(TOL_CYC)) begin
      lowCount <= lowCount + 32'h1;
    end
  end

  // High time since the last pulse; a pulse too soon is not forgiven
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      highCount <= 32'h0;
      gapMet <= 1'b0;
    end else if (!releaseSync) begin
      highCount <= 32'h0;
    end else begin
      if (highCount <= 32'(GAP_CYC)) begin
        highCount <= highCount + 32'h1;
      end
      // Gap judged when the next pulse starts
      gapMet <= (highCount > 32'(GAP_CYC));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Released state: cut once the low time exceeds the tolerance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      released <= RELEASE_RST;
    end else if (releaseSync && !released) begin
      // Only return after a full gap so start-up is not chattery
      if (highCount > 32'(GAP_CYC)) begin
        released <= 1'b1;
      end
    end else if (!releaseSync) begin
      if (lowCount >= 32'(TOL_CYC) || !gapMet) begin
        released <= 1'b0;
      end
    end
  end
endmodule // tos_release_filter

// [rtl/tos_string_torque_off.sv]
// Per-string torque release gating and torque-off status aggregation.
// Assumes release pins are asynchronous; drive info and fieldbus state come
// from the local fieldbus logic on clk.
module tos_string_torque_off
  import tos_pkg::*;
#(
  parameter int NSTR = NUM_STRINGS,
  parameter int NDRV = DRIVES_PER_STRING,
  parameter int TOL_CYC = PULSE_TOL_CYC,
  parameter int GAP_CYC = PULSE_GAP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NSTR-1:0] stringTorqueReleaseInput,
  input wire logic [NSTR-1:0] stringHardwareEnable,
  input wire logic systemBooting,
  input wire logic fieldbusOk,
  input tos_drive_info_t driveInfo [NSTR],
  output logic [NSTR-1:0] stringTorqueOffStatus,
  output logic [NSTR-1:0][NDRV-1:0] powerStagePermit,
  output logic [NSTR-1:0][NDRV-1:0] autoRestartAllowed
);
  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (NSTR < 1) begin : gBadStrings
    $error("tos_string_torque_off: at least one string is needed");
  end
  // The drive info struct fixes the drive count
  if (NDRV != DRIVES_PER_STRING) begin : gBadDrives
    $error("tos_string_torque_off: drive count must match drive info");
  end
  if (TOL_CYC < 1 || GAP_CYC < 1) begin : gBadCounts
    $error("tos_string_torque_off: filter counts must be at least one");
  end
  // Sync, filter and output stages must fit the reaction limit
  if (TOL_CYC + 4 > REACT_MAX_CYC) begin : gSlowCut
    $error("tos_string_torque_off: cut would be too slow");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  logic [NSTR-1:0] relMeta;
  logic [NSTR-1:0] relSync;
  logic [NSTR-1:0] hwMeta;
  logic [NSTR-1:0] hwSync;
  logic [NSTR-1:0] released;

  // Reset low: a release is never assumed across reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      relMeta <= '0;
      relSync <= '0;
    end else begin
      relMeta <= stringTorqueReleaseInput;
      relSync <= relMeta;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hwMeta <= '0;
      hwSync <= '0;
    end else begin
      hwMeta <= stringHardwareEnable;
      hwSync <= hwMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One filter per string; each sees only its own pin
  for (genvar s = 0; s < NSTR; s++) begin : gStr
    tos_release_filter #(
      .TOL_CYC(TOL_CYC),
      .GAP_CYC(GAP_CYC)
    ) uFilt (
      .clk(clk),
      .rst_n(rst_n),
      .releaseSync(relSync[s]),
      .released(released[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Power stage permits
  logic [NSTR-1:0][NDRV-1:0] standardPermit;
  logic [NSTR-1:0][NDRV-1:0] localPermit;
  logic [NSTR-1:0][NDRV-1:0] nextPermit;

  // Standard drives follow the string release and enable
  always_comb begin
    standardPermit = '0;
    for (int s = 0; s < NSTR; s++) begin
      standardPermit[s] = {NDRV{released[s] && hwSync[s]}} &
        ~driveInfo[s].localTorqueOffOption;
    end
  end

  // Local option drives ignore the string release
  always_comb begin
    localPermit = '0;
    for (int s = 0; s < NSTR; s++) begin
      localPermit[s] = driveInfo[s].localRelease &
        driveInfo[s].localTorqueOffOption & {NDRV{hwSync[s]}};
    end
  end

  always_comb begin
    nextPermit = standardPermit | localPermit;
  end

  // Registered so the permit lines never glitch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      powerStagePermit <= '0;
    end else begin
      powerStagePermit <= nextPermit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Auto restart mirrors the drive setting; the drive acts on it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      autoRestartAllowed <= '0;
    end else begin
      for (int s = 0; s < NSTR; s++) begin
        autoRestartAllowed[s] <= driveInfo[s].autoEnableAtPowerup;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status causes; informational only, not a safety path
  logic [NSTR-1:0] bootCause;
  logic [NSTR-1:0] releaseCause;
  logic [NSTR-1:0] commCause;
  logic [NSTR-1:0] emptyCause;
  logic [NSTR-1:0] busCause;
  logic [NSTR-1:0] driveCause;
  logic [NSTR-1:0] nextStatus;

  always_comb begin
    bootCause = '0;
    for (int s = 0; s < NSTR; s++) begin
      bootCause[s] = systemBooting;
    end
  end

  always_comb begin
    releaseCause = '0;
    for (int s = 0; s < NSTR; s++) begin
      releaseCause[s] = !released[s];
    end
  end

  always_comb begin
    commCause = '0;
    for (int s = 0; s < NSTR; s++) begin
      commCause[s] = |(driveInfo[s].present &
        driveInfo[s].commLost);
    end
  end

  always_comb begin
    emptyCause = '0;
    for (int s = 0; s < NSTR; s++) begin
      emptyCause[s] = ~|driveInfo[s].present;
    end
  end

  // A dead bus hides every drive, so all strings flag
  always_comb begin
    busCause = '0;
    for (int s = 0; s < NSTR; s++) begin
      busCause[s] = !fieldbusOk;
    end
  end

  // Absent drives cannot report, so their bits are masked
  always_comb begin
    driveCause = '0;
    for (int s = 0; s < NSTR; s++) begin
      driveCause[s] = |(driveInfo[s].present &
        driveInfo[s].driveTorqueOff);
    end
  end

  always_comb begin
    nextStatus = bootCause | releaseCause | commCause | emptyCause |
      busCause | driveCause;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stringTorqueOffStatus <= {NSTR{STATUS_RST}};
    end else begin
      stringTorqueOffStatus <= nextStatus;
    end
  end
endmodule // tos_string_torque_off

// [sim/tos_safety_ctrl.sv]
// Safety controller model driving the release pins.
// Assumes the bench sets the levels and asks for test pulses on string 0.
module tos_safety_ctrl (
  input wire logic clk,
  input wire logic [1:0] want,
  input wire logic go,
  output logic [1:0] rel
);
  timeunit 1ns;
  timeprecision 1ns;
  // No status input: status never steers this controller
  logic [1:0] cnt = 2'h0;
  // Moves just after the rising edge, like a real output stage
  always @(posedge clk) begin
    if (go) cnt <= 2'h3;
    else if (cnt != 2'h0) cnt <= cnt - 2'h1;
  end
  // Idle at the level set in want, high only where the bench asks
  assign rel = want & {1'h1, cnt == 2'h0};
endmodule // tos_safety_ctrl

// [sim/tos_string_torque_off_chk.sv]
// Port checker for the torque-off block, bound below.
// Assumes the filter tolerance is passed in from the bound instance.
module tos_chk
  import tos_pkg::*;
#(
  parameter int NSTR = 2,
  parameter int NDRV = 8,
  parameter int TOL_CYC = PULSE_TOL_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NSTR-1:0] stringTorqueReleaseInput,
  input wire logic [NSTR-1:0] stringHardwareEnable,
  input wire logic systemBooting,
  input wire logic fieldbusOk,
  input tos_drive_info_t driveInfo [NSTR],
  input wire logic [NSTR-1:0] stringTorqueOffStatus,
  input wire logic [NSTR-1:0][NDRV-1:0] powerStagePermit,
  input wire logic [NSTR-1:0][NDRV-1:0] autoRestartAllowed
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [NSTR-1:0] st = stringTorqueOffStatus;
  wire logic [NDRV-1:0] pm = powerStagePermit[0];
  wire logic rel = stringTorqueReleaseInput[0];
  tos_drive_info_t d;
  assign d = driveInfo[0];
  // Consecutive low samples of the string 0 release pin
  logic [31:0] lowRun;
  always_ff @(posedge clk) begin
    if (!rst_n || rel) begin
      lowRun <= 32'h0;
    end else if (lowRun != 32'hffffffff) begin
      lowRun <= lowRun + 32'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_BOOT: assert property (systemBooting |=> &st)
    else $error("status low in boot");
  AST_BUS: assert property (!fieldbusOk |=> &st)
    else $error("status low, bus down");
  AST_COMM: assert property (|d.commLost |=> st[0])
    else $error("status low, drive lost");
  AST_NONE: assert property (d.present == '0 |=> st[0])
    else $error("status low, no drive");
  AST_DRV: assert property (
    |(d.present & d.driveTorqueOff) |=> st[0]) else $error("drive missed");
  AST_AUTO: assert property (
    $past(rst_n) |-> autoRestartAllowed[0] == $past(d.autoEnableAtPowerup))
    else $error("auto restart copy wrong");
  AST_HWEN: assert property (
    !stringHardwareEnable[0] [*4] |-> pm == '0) else $error("permit, hw off");
  AST_OFF: assert property (
    lowRun >= 32'(TOL_CYC + 4) |->
      st[0] && (pm & ~d.localTorqueOffOption) == '0)
    else $error("torque not cut");
endmodule // tos_chk
bind tos_string_torque_off tos_chk #(.NSTR(NSTR), .NDRV(NDRV),
  .TOL_CYC(TOL_CYC)) chk (
  .clk(clk), .rst_n(rst_n), .systemBooting(systemBooting),
  .stringTorqueReleaseInput(stringTorqueReleaseInput),
  .stringHardwareEnable(stringHardwareEnable), .fieldbusOk(fieldbusOk),
  .driveInfo(driveInfo), .stringTorqueOffStatus(stringTorqueOffStatus),
  .powerStagePermit(powerStagePermit),
  .autoRestartAllowed(autoRestartAllowed));

// [sim/test_tos_string_torque_off.sv]
// Bench for the torque-off block with a safety controller model.
// Assumes small filter counts: TOL_CYC 5, GAP_CYC 20.
module test_tos_string_torque_off
  import tos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
  typedef struct packed {
    logic bt, fb;
    logic [7:0] pr, cl, dt;
    logic s;
  } tos_row_t;
  tos_row_t rows [6] = '{'{1'h1, 1'h1, 8'hff, 8'h00, 8'h00, 1'h1},
    '{1'h0, 1'h0, 8'hff, 8'h00, 8'h00, 1'h1},
    '{1'h0, 1'h1, 8'hff, 8'h04, 8'h00, 1'h1},
    '{1'h0, 1'h1, 8'h00, 8'h00, 8'h00, 1'h1},
    '{1'h0, 1'h1, 8'hff, 8'h00, 8'h01, 1'h1},
    '{1'h0, 1'h1, 8'hff, 8'h00, 8'h00, 1'h0}};
  logic clk = 1'h0, rst_n = 1'h0, boot = 1'h1, fbOk = 1'h1, go = 1'h0;
  logic [1:0] hwEn = 2'h3, want = 2'h1, rel, st;
  logic [1:0][7:0] pm, ar;
  tos_drive_info_t di [2];
  int n_fail = 0, comparisons = 0, i;
  always #50 clk = ~clk;
  tos_safety_ctrl ctl (.clk(clk), .want(want), .go(go), .rel(rel));
  tos_string_torque_off #(.TOL_CYC(5), .GAP_CYC(20)) DUT (.clk(clk),
    .rst_n(rst_n), .stringTorqueReleaseInput(rel),
    .stringHardwareEnable(hwEn), .systemBooting(boot), .fieldbusOk(fbOk),
    .driveInfo(di), .stringTorqueOffStatus(st), .powerStagePermit(pm),
    .autoRestartAllowed(ar));
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse();
    go = 1'h1;
    tick(1);
    `CHK(rel[0], 1'h0)
    go = 1'h0;
  endtask
  task give_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    foreach (di[k]) di[k] = '{8'hff, 8'h00, 8'h00, 8'h01, 8'h00, 8'h5a};
    tick(4);
    `CHK({st, pm}, 18'h30000)
    rst_n = 1'h1;
    tick(30);
    for (i = 0; i < 6; i++) begin
      foreach (di[k]) di[k][47:24] = {rows[i].pr, rows[i].cl, rows[i].dt};
      boot = rows[i].bt;
      fbOk = rows[i].fb;
      tick(3);
      `CHK(st, {1'h1, rows[i].s})
    end
    `CHK({pm, ar}, 32'h00fe5a5a)
    pulse();
    repeat (20) begin
      tick(1);
      `CHK(pm[0], 8'hfe)
    end
    // Second pulse comes too soon, so it must cut torque
    pulse();
    for (i = 0; i < 12 && st[0] !== 1'h1; i++) tick(1);
    `CHK(st[0], 1'h1)
    `CHK(pm[0], 8'h00)
    tick(40);
    `CHK(pm[0], 8'hfe)
    di[0].localRelease = 8'h01;
    tick(3);
    `CHK(pm[0], 8'hff)
    // Stop order: string disabled first, release removed later
    hwEn = 2'h0;
    tick(4);
    `CHK({st, pm}, 18'h20000)
    want = 2'h0;
    tick(16);
    `CHK({st, pm}, 18'h30000)
    want = 2'h1;
    tick(40);
    `CHK({st, pm}, 18'h20000)
    rst_n = 1'h0;
    tick(2);
    `CHK({st, pm}, 18'h30000)
    give_verdict();
  end
  initial begin
    #5ms;
    n_fail++;
    give_verdict();
  end
endmodule // test_tos_string_torque_off
